// [hdl/pirq_ctrl.sv]
// Purpose: PHY interrupt mask/status, auxiliary control/status and LED select registers on AHB-Lite
// Assumes: event pulses, indications and resets come from logic on hclk
// Notes: reads take one wait state, writes none; status reads clear enabled events
//
// The AHB-Lite interface to the registers is this design's own decision.
module pirq_ctrl #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] src_evt,
  input pirq_pkg::pirq_aux_ind_t aux_ind,
  input wire logic usb_reset,
  input wire logic lite_reset,
  input wire logic cfg_load,
  input wire logic eeprom_present,
  input pirq_pkg::pirq_cfg_t eeprom_val,
  input wire logic otp_present,
  input pirq_pkg::pirq_cfg_t otp_val,
  output logic phy_int_pin,
  output logic sys_irq,
  output logic [1:0] link_timeout_sel,
  output logic enhanced_phy_cfg_flag,
  output pirq_pkg::pirq_led_sel_t led_sel
);
  import pirq_pkg::*;

  if (ADDR_W < 12) begin : g_bad_addr_w
    $error("pirq_ctrl needs at least 12 address bits");
  end

  logic rd_pend_q;
  logic wr_pend_q;
  logic [ADDR_W-1:0] addr_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [31:0] hrdata_q;
  logic [15:0] mask_q;
  logic [15:0] pend_q;
  logic [15:0] clr;
  logic [15:0] status_view;
  logic [15:0] rd_word;
  logic [1:0] tmo_q;
  logic enh_q;
  logic [15:0] led_q;
  logic [SYS_EVT_W-1:0] sys_evt_q;
  logic [SYS_EVT_W-1:0] sys_msk_q;
  logic [SYS_EVT_W-1:0] sys_set;
  logic phy_int_q;
  logic sys_irq_q;
  logic acc;
  logic rd_fire;
  logic rd_status;
  logic restore;
  logic led_bad;
  pirq_cfg_t img;
  logic img_applied;

  // address compare at the bus width
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] r);
    hit = (a == ADDR_W'(r));
  endfunction : hit

  // hsize is not decoded: only whole-word transfers are supported
  assign acc = hsel && htrans[1] && hready;
  assign rd_fire = rd_pend_q;
  assign rd_status = rd_fire && hit(addr_q, ADDR_STATUS);
  assign restore = img_applied || usb_reset || lite_reset;

  // address phase capture; reads insert one wait state so a write just before is visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
      wr_pend_q <= 1'b0;
      addr_q <= '0;
      hreadyout_q <= 1'b1;
    end else begin
      rd_pend_q <= acc && !hwrite;
      wr_pend_q <= acc && hwrite;
      hreadyout_q <= !(acc && !hwrite);
      if (acc) begin
        addr_q <= haddr;
      end
    end
  end

  // pending latches; a status read clears only what the mask enables at that moment
  assign clr = rd_status ? (pend_q & mask_q) : '0;

  pirq_event_latch #(
    .WIDTH(16),
    .IMPL(SRC_IMPL)
  ) pirq_event_latch_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_pulse(src_evt),
    .clr(clr),
    .pend_q(pend_q)
  );

  pirq_cfg_image pirq_cfg_image_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .cfg_load(cfg_load),
    .eeprom_present(eeprom_present),
    .eeprom_val(eeprom_val),
    .otp_present(otp_present),
    .otp_val(otp_val),
    .img_q(img),
    .applied_q(img_applied)
  );

  // status word: masked pending flags plus summary gated by the global enable
  always_comb begin
    status_view = pend_q & mask_q & SRC_IMPL;
    status_view[BIT_SUMMARY] = mask_q[BIT_GLOBAL_EN] && ((pend_q & mask_q & SRC_IMPL) != '0);
  end

  // mask register; bit 6 never stores
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= MASK_RESET;
    end else if (wr_pend_q && hit(addr_q, ADDR_MASK)) begin
      mask_q <= hwdata[15:0] & MASK_WRITABLE;
    end
  end

  // timeout and enhanced-mode bits; an image restore outranks a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmo_q <= 2'h0;
      enh_q <= 1'b0;
    end else if (restore) begin
      tmo_q <= img.link_timeout;
      enh_q <= img.enhanced_phy_cfg_flag;
    end else if (wr_pend_q && hit(addr_q, ADDR_AUX)) begin
      tmo_q <= {hwdata[BIT_TMO_HI], hwdata[BIT_TMO_LO]};
      enh_q <= hwdata[BIT_ENH];
    end
  end

  // LED function selectors; reserved codes are stored but flagged
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      led_q <= LED_RESET;
    end else if (wr_pend_q && hit(addr_q, ADDR_LED)) begin
      led_q <= hwdata[15:0];
    end
  end

  // any selector written with a reserved function code
  always_comb begin
    led_bad = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!pirq_led_fn_ok(hwdata[i*4 +: 4])) begin
        led_bad = 1'b1;
      end
    end
  end

  // system event sources: pin rise, image restore, reserved LED code written
  always_comb begin
    sys_set = '0;
    sys_set[SYS_EVT_PIN] = status_view[BIT_SUMMARY] && !phy_int_q;
    sys_set[SYS_EVT_IMG] = restore;
    sys_set[SYS_EVT_LED] = wr_pend_q && hit(addr_q, ADDR_LED) && led_bad;
  end

  // sticky system events, write one to clear; a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_evt_q <= '0;
    end else if (wr_pend_q && hit(addr_q, ADDR_SYS_EVT)) begin
      sys_evt_q <= (sys_evt_q & ~hwdata[SYS_EVT_W-1:0]) | sys_set;
    end else begin
      sys_evt_q <= sys_evt_q | sys_set;
    end
  end

  // system event mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_msk_q <= '0;
    end else if (wr_pend_q && hit(addr_q, ADDR_SYS_MSK)) begin
      sys_msk_q <= hwdata[SYS_EVT_W-1:0];
    end
  end

  // interrupt outputs registered; both lag their cause by one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phy_int_q <= 1'b0;
      sys_irq_q <= 1'b0;
    end else begin
      phy_int_q <= status_view[BIT_SUMMARY];
      sys_irq_q <= (sys_evt_q & sys_msk_q) != '0;
    end
  end

  // read multiplexer; unmapped words and reserved bits read zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit(addr_q, ADDR_MASK)) begin
      rd_word = mask_q;
    end else if (hit(addr_q, ADDR_STATUS)) begin
      rd_word = status_view;
    end else if (hit(addr_q, ADDR_AUX)) begin
      rd_word = {aux_ind.an_complete, aux_ind.an_disabled, aux_ind.crossover, aux_ind.cd_swap,
                 aux_ind.polarity_abcd, tmo_q[1], enh_q, aux_ind.full_duplex, aux_ind.speed,
                 tmo_q[0], 2'b00};
    end else if (hit(addr_q, ADDR_LED)) begin
      rd_word = led_q;
    end else if (hit(addr_q, ADDR_SYS_EVT)) begin
      rd_word = {13'h0000, sys_evt_q};
    end else if (hit(addr_q, ADDR_SYS_MSK)) begin
      rd_word = {13'h0000, sys_msk_q};
    end
  end

  // read data held until the next read completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_fire) begin
      hrdata_q <= {16'h0000, rd_word};
    end
  end

  // the slave never answers with an error, but the response still leaves a flop like every bus output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign phy_int_pin = phy_int_q;
  assign sys_irq = sys_irq_q;
  assign link_timeout_sel = tmo_q;
  assign enhanced_phy_cfg_flag = enh_q;
  assign led_sel = led_q;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // pending, status and pin behaviour first, then bus timing, register stores and system events
  AST_STATUS_MASKED: assert property ((status_view[14:0] & ~mask_q[14:0]) == '0)
    else $error("status bit set with its mask clear");

  AST_PEND_SHOWS: assert property ((wr_pend_q && hit(addr_q, ADDR_MASK)
      && (pend_q & hwdata[15:0] & SRC_IMPL) != '0 && !rd_status)
      |=> ((status_view & $past(pend_q) & $past(hwdata[15:0])) != '0))
    else $error("pending event not shown after its mask was set");

  AST_READ_CLEARS: assert property (rd_status
      |=> ((pend_q & $past(pend_q & mask_q) & ~$past(src_evt)) == '0))
    else $error("enabled pending event survived a status read");

  AST_MASKED_SURVIVE: assert property (rd_status
      |=> ((pend_q & $past(pend_q & ~mask_q)) == $past(pend_q & ~mask_q)))
    else $error("masked pending event lost on a status read");

  AST_PIN_GATED: assert property (!mask_q[BIT_GLOBAL_EN] |=> !phy_int_pin)
    else $error("interrupt pin high without global enable");

  AST_PIN_FOLLOWS: assert property ((mask_q[BIT_GLOBAL_EN] && (pend_q & mask_q & SRC_IMPL) != '0)
      |=> phy_int_pin)
    else $error("interrupt pin low with an enabled pending event");

  AST_RSVD_ZERO: assert property (mask_q[BIT_RSVD] == 1'b0 && pend_q[BIT_RSVD] == 1'b0)
    else $error("reserved bit 6 holds a one");

  AST_RESTORE: assert property ((usb_reset || lite_reset)
      |=> ({link_timeout_sel, enhanced_phy_cfg_flag} == $past(img)))
    else $error("reset did not restore image defaults");

  AST_LATCH_SET: assert property ((src_evt & SRC_IMPL) != '0
      |=> ((pend_q & $past(src_evt & SRC_IMPL)) == $past(src_evt & SRC_IMPL)))
    else $error("event pulse not latched");

  AST_READ_WAIT: assert property ((acc && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read answer not after one wait state");

  AST_HRESP_OKAY: assert property (!hresp)
    else $error("bus error response driven");

  AST_WRITE_NO_WAIT: assert property ((acc && hwrite) |=> hreadyout)
    else $error("write answer delayed");

  AST_READ_DATA_STANDS: assert property (!rd_fire |=> $stable(hrdata))
    else $error("read data changed without a read");

  AST_MASK_WRITE: assert property ((wr_pend_q && hit(addr_q, ADDR_MASK))
      |=> (mask_q == ($past(hwdata[15:0]) & MASK_WRITABLE)))
    else $error("mask write not stored");

  AST_AUX_WRITE: assert property ((wr_pend_q && hit(addr_q, ADDR_AUX) && !restore)
      |=> (link_timeout_sel == {$past(hwdata[BIT_TMO_HI]), $past(hwdata[BIT_TMO_LO])}
      && enhanced_phy_cfg_flag == $past(hwdata[BIT_ENH])))
    else $error("auxiliary write not stored");

  AST_IMG_APPLY: assert property (img_applied
      |=> ({link_timeout_sel, enhanced_phy_cfg_flag} == $past(img)))
    else $error("loaded image not applied to the auxiliary defaults");

  AST_LED_WRITE: assert property ((wr_pend_q && hit(addr_q, ADDR_LED))
      |=> (led_sel == $past(hwdata[15:0])))
    else $error("LED selector write not stored");

  AST_LED_FLAG: assert property ((wr_pend_q && hit(addr_q, ADDR_LED) && led_bad)
      |=> sys_evt_q[SYS_EVT_LED])
    else $error("reserved LED code not flagged");

  AST_SYS_IRQ: assert property ((sys_evt_q & sys_msk_q) != '0 |=> sys_irq)
    else $error("system interrupt low with an enabled event");

  AST_SYS_SET_WINS: assert property (sys_set != '0
      |=> ((sys_evt_q & $past(sys_set)) == $past(sys_set)))
    else $error("system event lost against its clear");

  AST_SYS_CLEAR: assert property ((wr_pend_q && hit(addr_q, ADDR_SYS_EVT) && sys_set == '0)
      |=> ((sys_evt_q & $past(hwdata[SYS_EVT_W-1:0])) == '0))
    else $error("system event survived its clear");

  AST_SYS_PIN_EVENT: assert property ((status_view[BIT_SUMMARY] && !phy_int_pin) |=> sys_evt_q[SYS_EVT_PIN])
    else $error("interrupt pin rise not recorded");

  // main scenarios worth seeing in a run
  COV_FLUSH_READ: cover property (rd_status && (pend_q & mask_q) != '0 && !mask_q[BIT_GLOBAL_EN]);
  COV_PIN_RISE: cover property (!phy_int_pin ##1 phy_int_pin);
  COV_RESTORE: cover property (lite_reset && img != CFG_ZERO);
  COV_SET_DURING_CLEAR: cover property (rd_status && (src_evt & pend_q & mask_q & SRC_IMPL) != '0);
  COV_LED_RESERVED: cover property (sys_set[SYS_EVT_LED]);
endmodule : pirq_ctrl

// [hdl/pirq_pkg.sv]
// Purpose: constants, field layouts and carrier types of the PHY interrupt, auxiliary and LED register block
// Assumes: one clock (hclk, 100 MHz); registers reached over AHB-Lite, one aligned word per register
// Notes: register byte address is four times the register index
package pirq_pkg;
  // register indices and byte addresses
  localparam logic [9:0] IDX_MASK = 10'h019;
  localparam logic [9:0] IDX_STATUS = 10'h01A;
  localparam logic [9:0] IDX_AUX = 10'h01C;
  localparam logic [9:0] IDX_LED = 10'h01D;
  localparam logic [9:0] IDX_SYS_EVT = 10'h020;
  localparam logic [9:0] IDX_SYS_MSK = 10'h021;
  localparam logic [11:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [11:0] ADDR_AUX = {IDX_AUX, 2'b00};
  localparam logic [11:0] ADDR_LED = {IDX_LED, 2'b00};
  localparam logic [11:0] ADDR_SYS_EVT = {IDX_SYS_EVT, 2'b00};
  localparam logic [11:0] ADDR_SYS_MSK = {IDX_SYS_MSK, 2'b00};

  // mask and status layout
  localparam int unsigned BIT_GLOBAL_EN = 15;
  localparam int unsigned BIT_SUMMARY = 15;
  localparam int unsigned BIT_RSVD = 6;
  localparam logic [15:0] SRC_IMPL = 16'h7FBF;   // sources in 14:7 and 5:0
  localparam logic [15:0] MASK_WRITABLE = 16'hFFBF;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // auxiliary writable fields
  localparam int unsigned BIT_TMO_HI = 7;
  localparam int unsigned BIT_ENH = 6;
  localparam int unsigned BIT_TMO_LO = 2;

  // LED function selectors
  localparam logic [15:0] LED_RESET = 16'h8021;

  // own event register layout
  localparam int unsigned SYS_EVT_W = 3;
  localparam int unsigned SYS_EVT_PIN = 0;
  localparam int unsigned SYS_EVT_IMG = 1;
  localparam int unsigned SYS_EVT_LED = 2;

  typedef enum logic [3:0] {
    PIRQ_LED_LINK_ACT = 4'h0,
    PIRQ_LED_LINK1000_ACT = 4'h1,
    PIRQ_LED_LINK100_ACT = 4'h2,
    PIRQ_LED_DUPLEX_COL = 4'h8,
    PIRQ_LED_COLLISION = 4'h9,
    PIRQ_LED_ACTIVITY = 4'hA,
    PIRQ_LED_NEG_FAULT = 4'hC,
    PIRQ_LED_FORCE_OFF = 4'hE,
    PIRQ_LED_FORCE_ON = 4'hF
  } pirq_led_fn_t;

  typedef struct packed {
    logic [3:0] indicator_pin_three;
    logic [3:0] indicator_pin_two;
    logic [3:0] indicator_pin_one;
    logic [3:0] indicator_pin_zero;
  } pirq_led_sel_t;

  typedef struct packed {
    logic an_complete;
    logic an_disabled;
    logic crossover;
    logic cd_swap;
    logic [3:0] polarity_abcd;
    logic full_duplex;
    logic [1:0] speed;
  } pirq_aux_ind_t;

  typedef struct packed {
    logic [1:0] link_timeout;
    logic enhanced_phy_cfg_flag;
  } pirq_cfg_t;

  localparam pirq_cfg_t CFG_ZERO = 3'h0;

  // true for LED function codes the indicator logic serves
  function automatic logic pirq_led_fn_ok(input logic [3:0] code);
    unique case (code)
      PIRQ_LED_LINK_ACT, PIRQ_LED_LINK1000_ACT, PIRQ_LED_LINK100_ACT, PIRQ_LED_DUPLEX_COL,
      PIRQ_LED_COLLISION, PIRQ_LED_ACTIVITY, PIRQ_LED_NEG_FAULT, PIRQ_LED_FORCE_OFF,
      PIRQ_LED_FORCE_ON: pirq_led_fn_ok = 1'b1;
      default: pirq_led_fn_ok = 1'b0;
    endcase
  endfunction : pirq_led_fn_ok
endpackage : pirq_pkg

// [hdl/pirq_event_latch.sv]
// Purpose: per-source pending latches of the PHY interrupt block
// Assumes: set and clear come from logic on hclk
// Notes: a set arriving with its clear keeps the latch set
module pirq_event_latch #(
  parameter int unsigned WIDTH = 16,
  parameter logic [15:0] IMPL = 16'hFFFF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] set_pulse,
  input wire logic [WIDTH-1:0] clr,
  output logic [WIDTH-1:0] pend_q
);
  if (WIDTH != 16) begin : g_bad_width
    $error("pirq_event_latch serves exactly 16 bits");
  end

  // set beats clear so an event during the clearing read is not lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= '0;
    end else begin
      pend_q <= ((pend_q & ~clr) | set_pulse) & IMPL;
    end
  end
endmodule : pirq_event_latch

// [hdl/pirq_cfg_image.sv]
// Purpose: keeps the last loaded configuration image for the auxiliary defaults
// Assumes: load strobe and image sources are on hclk
// Notes: the eeprom image wins over otp; without either the image is zero
module pirq_cfg_image (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cfg_load,
  input wire logic eeprom_present,
  input pirq_pkg::pirq_cfg_t eeprom_val,
  input wire logic otp_present,
  input pirq_pkg::pirq_cfg_t otp_val,
  output pirq_pkg::pirq_cfg_t img_q,
  output logic applied_q
);
  import pirq_pkg::*;

  // image selection by source priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      img_q <= CFG_ZERO;
    end else if (cfg_load) begin
      if (eeprom_present) begin
        img_q <= eeprom_val;
      end else if (otp_present) begin
        img_q <= otp_val;
      end else begin
        img_q <= CFG_ZERO;
      end
    end
  end

  // one-cycle strobe telling the register file to take the fresh image
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied_q <= 1'b0;
    end else begin
      applied_q <= cfg_load;
    end
  end
endmodule : pirq_cfg_image

// [bench/pirq_ctrl_tb.sv]
// Purpose: self-checking bench for the PHY interrupt, auxiliary and LED register block
// Assumes: one AHB-Lite master, hready tied to hreadyout, all stimulus on hclk
// Notes: bus answers are taken at the rising edge that sees ready; levels are compared at the falling edge
module pirq_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pirq_pkg::*;

  localparam logic [31:0] O_PIN = 32'h0000_0001;
  localparam logic [31:0] O_SYS = 32'h0000_0002;
  localparam logic [31:0] O_CFG = 32'h0000_001C;
  localparam logic [31:0] O_LED = 32'hFFFF_0000;

  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd, outs;
  logic [15:0] src_evt;
  pirq_aux_ind_t aux_ind;
  logic usb_reset, lite_reset, cfg_load, eeprom_present, otp_present;
  pirq_cfg_t eeprom_val, otp_val;
  logic phy_int_pin, sys_irq, enhanced_phy_cfg_flag;
  logic [1:0] link_timeout_sel;
  pirq_led_sel_t led_sel;
  int n_mismatch = 0;
  int samples_checked = 0;

  // single slave, so its ready is the bus ready; outputs gathered for one compare task
  assign hready = hreadyout;
  assign outs = {led_sel, 11'h0, enhanced_phy_cfg_flag, link_timeout_sel, sys_irq, phy_int_pin};

  pirq_ctrl #(.ADDR_W(12)) pirq_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_evt(src_evt), .aux_ind(aux_ind),
    .usb_reset(usb_reset), .lite_reset(lite_reset), .cfg_load(cfg_load), .eeprom_present(eeprom_present),
    .eeprom_val(eeprom_val), .otp_present(otp_present), .otp_val(otp_val), .phy_int_pin(phy_int_pin),
    .sys_irq(sys_irq), .link_timeout_sel(link_timeout_sel), .enhanced_phy_cfg_flag(enhanced_phy_cfg_flag),
    .led_sel(led_sel));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // output levels are compared off the edge so no update race can decide the result
  task automatic chk_out(input logic [31:0] m, input logic [31:0] exp, input string what);
    @(negedge hclk);
    chk(outs & m, exp & m, what);
    @(posedge hclk);
  endtask : chk_out

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // one bus phase: ready and data are taken at the rising edge that sees ready; only the watchdog ends a hang
  task automatic wait_ready(output logic [31:0] d);
    logic r;
    do begin
      @(posedge hclk);
      r = hreadyout;
      d = hrdata;
    end while (r !== 1'b1);
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask : wait_ready

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready(d);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd, rd);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp, what);
  endtask : rd_chk

  task automatic pulse(input logic [15:0] e);
    src_evt <= e;
    @(posedge hclk);
    src_evt <= 16'h0;
    @(posedge hclk);
  endtask : pulse

  function automatic logic [31:0] aux_exp(input logic [10:0] ind, input logic [1:0] t, input logic enh);
    return {16'h0, ind[10:3], t[1], enh, ind[2:0], t[0], 2'b00};
  endfunction : aux_exp

  task automatic t_reset();
    rd_chk(ADDR_MASK, 32'h0, "mask reset");
    rd_chk(ADDR_STATUS, 32'h0, "status reset");
    rd_chk(ADDR_AUX, aux_exp(11'h5A5, 2'b00, 1'b0), "aux reset");
    rd_chk(ADDR_LED, 32'h0000_8021, "led reset");
    chk_out(O_PIN | O_SYS | O_CFG | O_LED, 32'h8021_0000, "outputs reset");
    rd_chk(12'hFFC, 32'h0, "unmapped");
  endtask : t_reset

  task automatic t_all_bits();
    wr(ADDR_MASK, 32'hFFFF_FFFF);
    rd_chk(ADDR_MASK, 32'h0000_FFBF, "mask bits");
    pulse(16'hFFFF);
    rd_chk(ADDR_STATUS, 32'h0000_FFBF, "all sources");
    rd_chk(ADDR_STATUS, 32'h0, "read clear");
    pulse(16'hFFFF);
    wr(ADDR_STATUS, 32'h0);
    rd_chk(ADDR_STATUS, 32'h0000_FFBF, "status write");
    wr(ADDR_MASK, 32'h0);
  endtask : t_all_bits

  // software side follows the set-masks, flush, enable order
  task automatic t_masked();
    pulse(16'h4001);
    tick(5);
    rd_chk(ADDR_STATUS, 32'h0, "masked hidden");
    wr(ADDR_MASK, 32'h4000);
    rd_chk(ADDR_STATUS, 32'h4000, "pending shows");
    chk_out(O_PIN, 32'h0, "pin no enable");
    rd_chk(ADDR_STATUS, 32'h0, "enabled cleared");
    wr(ADDR_MASK, 32'h4001);
    rd_chk(ADDR_STATUS, 32'h0001, "masked survived");
    wr(ADDR_MASK, 32'hC001);
    tick(2);
    chk_out(O_PIN, 32'h0, "no stale pin");
    pulse(16'h4000);
    tick(4);
    chk_out(O_PIN, O_PIN, "pin on event");
    rd_chk(ADDR_STATUS, 32'hC000, "summary");
    tick(2);
    chk_out(O_PIN, 32'h0, "pin cleared");
    wr(ADDR_MASK, 32'h4001);
    pulse(16'h4000);
    tick(2);
    chk_out(O_PIN, 32'h0, "pin gated");
    rd_chk(ADDR_STATUS, 32'h4000, "summary gated");
    wr(ADDR_MASK, 32'h0);
  endtask : t_masked

  task automatic load_img(input logic ep, input logic op, input logic [2:0] et, input string what);
    eeprom_present <= ep;
    otp_present <= op;
    cfg_load <= 1'b1;
    @(posedge hclk);
    cfg_load <= 1'b0;
    tick(2);
    chk_out(O_CFG, {27'h0, et, 2'b00}, what);
  endtask : load_img

  task automatic restore(input logic usb, input logic [2:0] et, input string what);
    wr(ADDR_AUX, 32'hFFFF);
    usb_reset <= usb;
    lite_reset <= ~usb;
    @(posedge hclk);
    usb_reset <= 1'b0;
    lite_reset <= 1'b0;
    tick(1);
    chk_out(O_CFG, {27'h0, et, 2'b00}, what);
  endtask : restore

  task automatic t_aux();
    logic [1:0] t;
    aux_ind <= 11'h25A;
    for (int c = 0; c < 4; c++) begin
      t = c[1:0];
      wr(ADDR_AUX, {16'hFFFF, 8'hFF, t[1], t[0], 3'h7, t[0], 2'h3});
      rd_chk(ADDR_AUX, aux_exp(11'h25A, t, t[0]), "aux fields");
      chk_out(O_CFG, {27'h0, t[0], t, 2'b00}, "timeout code");
    end
    load_img(1'b1, 1'b1, 3'b110, "eeprom image");
    restore(1'b1, 3'b110, "usb restore");
    restore(1'b0, 3'b110, "lite restore");
    load_img(1'b0, 1'b1, 3'b001, "otp image");
    restore(1'b1, 3'b001, "otp restore");
    load_img(1'b0, 1'b0, 3'b000, "no image");
    restore(1'b0, 3'b000, "zero restore");
  endtask : t_aux

  // every listed code, rotated over the four pins, then a reserved code raises the system event
  task automatic t_led();
    logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'hA, 4'hC, 4'hE, 4'hF};
    logic [15:0] v;
    wr(ADDR_SYS_EVT, 32'h7);
    foreach (codes[i]) begin
      v = {codes[i], codes[(i + 1) % 9], codes[(i + 2) % 9], codes[(i + 3) % 9]};
      wr(ADDR_LED, {16'hFFFF, v});
      rd_chk(ADDR_LED, {16'h0, v}, "led readback");
      chk_out(O_LED, {v, 16'h0}, "led output");
    end
    rd_chk(ADDR_SYS_EVT, 32'h0, "no flag");
    wr(ADDR_LED, 32'h0000_8073);
    rd_chk(ADDR_SYS_EVT, 32'h4, "reserved flag");
    chk_out(O_SYS, 32'h0, "irq masked");
    wr(ADDR_SYS_MSK, 32'h4);
    tick(1);
    chk_out(O_SYS, O_SYS, "irq raised");
    wr(ADDR_SYS_EVT, 32'h4);
    tick(1);
    chk_out(O_SYS, 32'h0, "irq cleared");
  endtask : t_led

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    src_evt = 16'h0;
    aux_ind = 11'h5A5;
    usb_reset = 1'b0;
    lite_reset = 1'b0;
    cfg_load = 1'b0;
    eeprom_present = 1'b0;
    otp_present = 1'b0;
    eeprom_val = 3'b101;
    otp_val = 3'b010;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_all_bits();
    t_masked();
    t_aux();
    t_led();
    results();
  end

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    results();
  end
endmodule : pirq_ctrl_tb
